// *** cav_pkg.sv ***
// shared constants for the address forming and interrupt vectoring unit
package cav_pkg;
    localparam int AW = 16;
    localparam int PAW = 20;
    localparam logic [7:0] VEC_DIV = 8'h00;
    localparam logic [7:0] VEC_STEP = 8'h01;
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_BRK = 8'h03;
    localparam logic [7:0] VEC_OVF = 8'h04;
    localparam logic [7:0] VEC_BOUND = 8'h05;
    localparam logic [7:0] VEC_UNUSED = 8'h06;
    localparam logic [7:0] VEC_ESC = 8'h07;
    localparam logic [7:0] VEC_TMR0 = 8'h08;
    localparam logic [7:0] VEC_DMA0 = 8'h0a;
    localparam logic [7:0] VEC_DMA1 = 8'h0b;
    localparam logic [7:0] VEC_EXT0 = 8'h0c;
    localparam logic [7:0] VEC_NUM = 8'h10;
    localparam logic [7:0] VEC_TMR1 = 8'h12;
    localparam logic [7:0] VEC_TMR2 = 8'h13;
    localparam logic [7:0] VEC_RSV_LAST = 8'h1f;
    localparam logic [15:0] PORT_RSV_LO = 16'h00f8;
    localparam logic [15:0] PORT_RSV_HI = 16'h00ff;
    localparam int VEC_SHIFT = 2;
    localparam logic [15:0] CS_WORD_OFS = 16'h0002;
    localparam int FLAG_IE = 9;
    localparam int FLAG_TS = 8;
    localparam int NSRC = 13;
    // base register select
    typedef enum logic [1:0] {CAV_BASE_NONE, CAV_BASE_GEN,
                              CAV_BASE_FRAME} cav_base_e;
    typedef enum logic [1:0] {CAV_IDX_NONE, CAV_IDX_SRC,
                              CAV_IDX_DST} cav_idx_e;
    typedef enum logic [1:0] {CAV_DISP_NONE, CAV_DISP_8,
                              CAV_DISP_16} cav_disp_e;
    typedef enum logic [1:0] {CAV_SEG_ES, CAV_SEG_CS, CAV_SEG_SS,
                              CAV_SEG_DS} cav_seg_e;
    typedef enum logic [2:0] {CAV_IDLE, CAV_ACK, CAV_PUSH_FL, CAV_PUSH_CS,
                              CAV_PUSH_IP, CAV_RD_IP, CAV_RD_CS,
                              CAV_DONE} cav_state_e;
endpackage

// *** cav_unit.sv ***
// effective address forming and interrupt vectoring unit
// How it works
// - offset sum in 16 bits, carry dropped
// - 8-bit displacement sign extended first
// - 27 memory modes from base/index/disp
// - address from segment plus offset, override
// - io port from 8-bit field or register
// - push status, code segment, pointer
// - escape trap returns to escape or prefix
// - other exceptions return to next instruction
// - 256 vectors, types 0..31 reserved
// - vector address is type times four
// - internal vectors; cascaded controller gives byte
// - hardware requests sampled at instruction end
// - nesting allowed once interrupts re-enabled
// - divide overflow raises type 0
// - trap step raises type 1 unless no_step_instr
// - stepping vector clears trap step flag
// - predefined exception types and priorities
// - peripheral and external types and priorities
// - nmi clears enable, no acknowledge
`timescale 1ns/1ps
module cav_unit
    import cav_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // operand address request
    input wire cav_base_e base_sel,
    input wire cav_idx_e idx_sel,
    input wire cav_disp_e disp_sel,
    input wire logic [15:0] disp,
    input wire logic [15:0] base_reg_general,
    input wire logic [15:0] stack_frame_base_reg,
    input wire logic [15:0] source_index_reg,
    input wire logic [15:0] destination_index_reg,
    input wire logic string_op,
    input wire logic seg_override,
    input wire cav_seg_e seg_override_sel,
    input wire logic [15:0] seg_es,
    input wire logic [15:0] seg_cs,
    input wire logic [15:0] seg_ss,
    input wire logic [15:0] seg_ds,
    // io port request
    input wire logic port_from_reg,
    input wire logic [7:0] port_imm,
    input wire logic [15:0] port_address_reg,
    // instruction boundary and exceptions
    input wire logic instr_end,
    input wire logic [15:0] instruction_pointer_reg,
    input wire logic [15:0] next_ip,
    input wire logic [15:0] escape_ip,
    input wire logic [15:0] status_word,
    input wire logic [15:0] stack_ptr,
    input wire logic div_overflow,
    input wire logic sw_int,
    input wire logic [7:0] sw_int_type,
    input wire logic ovf_trap,
    input wire logic bound_fail,
    input wire logic unused_op,
    input wire logic coprocessor_escape_opcode,
    input wire logic esc_trap_en,
    input wire logic numerics_err,
    input wire logic no_step_instr,
    // hardware sources
    input wire logic nmi_req,
    input wire logic [2:0] timer_req,
    input wire logic [1:0] dma_req,
    input wire logic [3:0] ext_req,
    input wire logic [3:0] ext_cascaded,
    // memory port for stack and vector table
    input wire logic mem_ready,
    input wire logic [15:0] mem_rdata,
    input wire logic [7:0] ack_vector,
    // address outputs
    output logic [15:0] eff_offset,
    output logic [19:0] phys_addr,
    output logic [15:0] io_port,
    output logic io_reserved,
    // vectoring outputs
    output logic busy,
    output logic ack_cycle,
    output logic mem_req,
    output logic mem_write,
    output logic [19:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic vec_done,
    output logic [7:0] vec_type,
    output logic [15:0] new_ip,
    output logic [15:0] new_cs,
    output logic [15:0] new_status
);
    typedef struct packed {
        cav_state_e st;
        logic [7:0] vtype;
        logic [15:0] ret_ip;
        logic [15:0] sp;
        logic [15:0] ip;
        logic [15:0] cs;
        logic [15:0] flags;
        logic done;
        logic [4:0] pin_s1;
        logic [4:0] pin_s2;
        logic [4:0] pin_s3;
        logic [4:0] pin_seen;
    } cav_state_s;

    cav_state_s q, next_q;
    logic [15:0] disp16, base_v, idx_v, seg_v, vaddr;
    logic [NSRC-1:0] hw_req;
    logic [7:0] hw_type [NSRC];
    logic hw_any, hw_ext;
    logic [7:0] hw_vec;
    logic [$clog2(NSRC)-1:0] hw_idx;
    logic nmi_pin;
    logic [3:0] ext_pin;

    function automatic logic [19:0] phys(input logic [15:0] s,
                                         input logic [15:0] o);
        phys = {s, 4'h0} + {4'h0, o};
    endfunction

    // address forming
    always_comb begin
        disp16 = 16'h0000;
        if (disp_sel == CAV_DISP_8) begin
            disp16 = {{8{disp[7]}}, disp[7:0]};
        end else if (disp_sel == CAV_DISP_16) begin
            disp16 = disp;
        end
        base_v = 16'h0000;
        if (base_sel == CAV_BASE_GEN) begin
            base_v = base_reg_general;
        end else if (base_sel == CAV_BASE_FRAME) begin
            base_v = stack_frame_base_reg;
        end
        idx_v = 16'h0000;
        if (idx_sel == CAV_IDX_SRC) begin
            idx_v = source_index_reg;
        end else if (idx_sel == CAV_IDX_DST) begin
            idx_v = destination_index_reg;
        end
        // any mix of the three parts; carry out of bit 15 is lost
        eff_offset = 16'(disp16 + base_v + idx_v);
        // implicit choice: frame base uses stack, string dest uses extra
        if (seg_override) begin
            seg_v = (seg_override_sel == CAV_SEG_ES) ? seg_es :
                    (seg_override_sel == CAV_SEG_CS) ? seg_cs :
                    (seg_override_sel == CAV_SEG_SS) ? seg_ss : seg_ds;
        end else if (base_sel == CAV_BASE_FRAME) begin
            seg_v = seg_ss;
        end else if (string_op && idx_sel == CAV_IDX_DST) begin
            seg_v = seg_es;
        end else begin
            seg_v = seg_ds;
        end
        phys_addr = phys(seg_v, eff_offset);
        io_port = port_from_reg ? port_address_reg
                                : {8'h00, port_imm};
        // only reported; keeping off these ports is software's duty
        io_reserved = io_port >= PORT_RSV_LO
                      && io_port <= PORT_RSV_HI;
    end

    // hardware sources in default priority order, highest first
    assign {nmi_pin, ext_pin} = q.pin_seen;
    assign hw_req = {ext_pin, dma_req, timer_req, nmi_pin,
                     3'b000};
    assign hw_type[0] = 8'h00;
    assign hw_type[1] = 8'h00;
    assign hw_type[2] = 8'h00;
    assign hw_type[3] = VEC_NMI;
    assign hw_type[4] = VEC_TMR0;
    assign hw_type[5] = VEC_TMR1;
    assign hw_type[6] = VEC_TMR2;
    assign hw_type[7] = VEC_DMA0;
    assign hw_type[8] = VEC_DMA1;
    generate
        for (genvar g = 0; g < 4; g++) begin : g_ext
            assign hw_type[9 + g] = 8'(VEC_EXT0 + g);
        end
    endgenerate

    always_comb begin
        hw_any = 1'b0;
        hw_idx = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (hw_req[i]) begin
                hw_any = 1'b1;
                hw_idx = ($clog2(NSRC))'(i);
            end
        end
        hw_vec = hw_type[hw_idx];
        hw_ext = hw_idx >= 4'(9) && ext_cascaded[2'(hw_idx - 4'(9))];
    end

    assign vaddr = 16'(q.vtype) << VEC_SHIFT;

    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        // pins are asynchronous: three stages, taken when last two agree
        next_q.pin_s1 = {nmi_req, ext_req};
        next_q.pin_s2 = q.pin_s1;
        next_q.pin_s3 = q.pin_s2;
        next_q.pin_seen = (q.pin_s2 & q.pin_s3)
                          | (q.pin_seen & (q.pin_s2 | q.pin_s3));
        case (q.st)
            CAV_IDLE: begin
                // only at instruction end; software first
                if (instr_end) begin
                    next_q.sp = stack_ptr;
                    next_q.flags = status_word;
                    next_q.ret_ip = next_ip;
                    next_q.st = CAV_PUSH_FL;
                    if (div_overflow) begin
                        next_q.vtype = VEC_DIV;
                    end else if (coprocessor_escape_opcode
                                 && esc_trap_en) begin
                        next_q.vtype = VEC_ESC;
                        next_q.ret_ip = escape_ip;
                    end else if (unused_op) begin
                        next_q.vtype = VEC_UNUSED;
                    end else if (bound_fail) begin
                        next_q.vtype = VEC_BOUND;
                    end else if (ovf_trap) begin
                        next_q.vtype = VEC_OVF;
                    end else if (numerics_err) begin
                        next_q.vtype = VEC_NUM;
                    end else if (sw_int) begin
                        next_q.vtype = sw_int_type;
                    end else if (status_word[FLAG_TS] && !no_step_instr) begin
                        next_q.vtype = VEC_STEP;
                    end else if (nmi_pin) begin
                        next_q.vtype = VEC_NMI;
                    end else if (hw_any && status_word[FLAG_IE]) begin
                        // enable flag gates nesting
                        next_q.vtype = hw_vec;
                        if (hw_ext) begin
                            next_q.st = CAV_ACK;
                        end
                    end else begin
                        next_q.st = CAV_IDLE;
                    end
                end
            end
            CAV_ACK: begin
                if (mem_ready) begin
                    next_q.vtype = ack_vector;
                    next_q.st = CAV_PUSH_FL;
                end
            end
            CAV_PUSH_FL, CAV_PUSH_CS, CAV_PUSH_IP: begin
                if (mem_ready) begin
                    next_q.sp = 16'(q.sp - CS_WORD_OFS);
                    next_q.st = (q.st == CAV_PUSH_FL) ? CAV_PUSH_CS :
                                (q.st == CAV_PUSH_CS) ? CAV_PUSH_IP
                                                      : CAV_RD_IP;
                end
            end
            CAV_RD_IP: begin
                if (mem_ready) begin
                    next_q.ip = mem_rdata;
                    next_q.st = CAV_RD_CS;
                end
            end
            CAV_RD_CS: begin
                if (mem_ready) begin
                    next_q.cs = mem_rdata;
                    next_q.st = CAV_DONE;
                end
            end
            default: begin
                next_q.done = 1'b1;
                next_q.st = CAV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // memory port driven from state; the sp copy is the pre-push value
    always_comb begin
        ack_cycle = q.st == CAV_ACK;
        mem_req = q.st inside {CAV_PUSH_FL, CAV_PUSH_CS, CAV_PUSH_IP,
                               CAV_RD_IP, CAV_RD_CS};
        mem_write = q.st inside {CAV_PUSH_FL, CAV_PUSH_CS, CAV_PUSH_IP};
        mem_addr = phys(seg_ss, 16'(q.sp - CS_WORD_OFS));
        mem_wdata = 16'h0000;
        case (q.st)
            CAV_PUSH_FL: mem_wdata = q.flags;
            CAV_PUSH_CS: mem_wdata = seg_cs;
            CAV_PUSH_IP: mem_wdata = q.ret_ip;
            CAV_RD_IP: mem_addr = {4'h0, vaddr};
            CAV_RD_CS: mem_addr = {4'h0, 16'(vaddr + CS_WORD_OFS)};
            default: mem_wdata = 16'h0000;
        endcase
    end

    assign busy = q.st != CAV_IDLE;
    assign vec_done = q.done;
    assign vec_type = q.vtype;
    assign new_ip = q.ip;
    assign new_cs = q.cs;
    // every vectoring masks interrupts and stops stepping
    assign new_status = q.flags & ~(16'(1) << FLAG_IE)
                        & ~(16'(1) << FLAG_TS);
endmodule

// *** cav_unit_properties.sv ***
// port assertions for the vectoring unit
`timescale 1ns/1ps
module cav_properties
    import cav_pkg::*;
(
    // clock, reset and io port
    input wire logic clk,
    input wire logic rst,
    input wire logic port_from_reg,
    input wire logic [7:0] port_imm,
    input wire logic [15:0] port_address_reg,
    input wire logic [15:0] io_port,
    // vectoring
    input wire logic instr_end,
    input wire logic busy,
    input wire logic div_overflow,
    input wire logic [15:0] status_word,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic vec_done,
    input wire logic [7:0] vec_type,
    input wire logic [15:0] new_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    io_imm_a: assert property (
        !port_from_reg |-> io_port == {8'h00, port_imm})
        else $error("io imm");
    io_reg_a: assert property (
        port_from_reg |-> io_port == port_address_reg)
        else $error("io reg");
    div_taken_a: assert property (
        instr_end && !busy && div_overflow |-> ##[1:40] vec_done
        && vec_type == VEC_DIV) else $error("div");
    vec_fetch_a: assert property (
        vec_done |-> $past(mem_addr, 2) == {10'h000, vec_type, 2'b10})
        else $error("vector fetch");
    step_clr_a: assert property (
        vec_done && vec_type == VEC_STEP |-> !new_status[FLAG_TS])
        else $error("step flag");
    nmi_mask_a: assert property (
        vec_done && vec_type == VEC_NMI |-> !new_status[FLAG_IE])
        else $error("nmi enable");
    push_first_a: assert property (
        mem_req && mem_write && !$past(mem_write) |-> mem_wdata == status_word)
        else $error("status push");
    tbl_range_a: assert property (
        mem_req && !mem_write |-> mem_addr < 20'h00400)
        else $error("table range");
endmodule

// *** cav_mem_model.sv ***
// far-side memory and cascaded interrupt controller model
`timescale 1ns/1ps
module cav_mem_model (
    // requests from the unit
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic ack_cycle,
    input wire logic [19:0] mem_addr,
    input wire logic slow,
    input wire logic [7:0] casc_vec,
    // answers
    output logic mem_ready,
    output logic [15:0] mem_rdata,
    output logic [7:0] ack_vector
);
    logic [1:0] cnt;
    // table word scrambles its address so a wrong fetch cannot match
    wire logic [15:0] word = mem_addr[15:0] ^ 16'ha5c3;
    // idle lines show the inverse, stale data never passes
    assign mem_rdata = mem_ready ? word : ~word;
    assign ack_vector = mem_ready && ack_cycle ? casc_vec
                                               : ~casc_vec;
    always_ff @(posedge clk) begin
        if (rst || mem_ready || !(mem_req || ack_cycle)) begin
            mem_ready <= 1'b0;
            cnt <= 2'd0;
        end else if (cnt == (slow ? 2'd2 : 2'd0)) begin
            mem_ready <= 1'b1;
        end else begin
            cnt <= cnt + 2'd1;
        end
    end
endmodule

// *** test_cpu_addressing_and_interrupt_vectoring.sv ***
// self-checking bench for the address and vectoring unit
`timescale 1ns/1ps
module test_cpu_addressing_and_interrupt_vectoring
    import cav_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic string_op, seg_override, port_from_reg, instr_end, no_step_instr;
    logic ie, slow, mem_ready, io_reserved, busy, ack_cycle, mem_req;
    logic mem_write, vec_done;
    cav_base_e base_sel;
    cav_idx_e idx_sel;
    cav_disp_e disp_sel;
    cav_seg_e seg_override_sel, s;
    logic [15:0] disp, bx, bp, si, di, es, cs, ss, ds, dx, nip, eip, sp, cz;
    logic [15:0] r, eo, mem_rdata, eff_offset, io_port, new_ip, new_cs;
    logic [15:0] new_status, mem_wdata, wq[$];
    logic [15:0] lf = 16'h000f;
    logic [19:0] phys_addr, mem_addr;
    logic [7:0] port_imm, ack_vector, vec_type;
    logic [7:0] tbl[16] = '{VEC_DIV, VEC_ESC, VEC_UNUSED, VEC_BOUND, VEC_OVF,
        VEC_NUM, VEC_BRK, VEC_STEP, VEC_NMI, VEC_TMR0, VEC_TMR1, VEC_TMR2,
        VEC_DMA0, VEC_DMA1, VEC_EXT0, 8'h47};
    int fail_count = 0;
    int comparisons = 0;
    int acks;
    cav_unit dut (.clk, .rst, .base_sel, .idx_sel, .disp_sel, .disp,
        .base_reg_general(bx), .stack_frame_base_reg(bp),
        .source_index_reg(si), .destination_index_reg(di), .string_op,
        .seg_override, .seg_override_sel, .seg_es(es), .seg_cs(cs),
        .seg_ss(ss), .seg_ds(ds), .port_from_reg, .port_imm,
        .port_address_reg(dx), .instr_end, .instruction_pointer_reg(eip),
        .next_ip(nip), .escape_ip(eip), .status_word({6'h00, ie, cz[7],
        8'h5a}), .stack_ptr(sp), .div_overflow(cz[0]), .sw_int(cz[6]),
        .sw_int_type(VEC_BRK), .ovf_trap(cz[4]), .bound_fail(cz[3]),
        .unused_op(cz[2]), .coprocessor_escape_opcode(cz[1]),
        .esc_trap_en(cz[1]), .numerics_err(cz[5]), .no_step_instr,
        .nmi_req(cz[8]), .timer_req(cz[11:9]), .dma_req(cz[13:12]),
        .ext_req({2'b00, cz[15:14]}), .ext_cascaded(4'b0010), .mem_ready,
        .mem_rdata, .ack_vector, .eff_offset, .phys_addr, .io_port,
        .io_reserved, .busy, .ack_cycle, .mem_req, .mem_write, .mem_addr,
        .mem_wdata, .vec_done, .vec_type, .new_ip, .new_cs, .new_status);
    cav_mem_model mem (.clk, .rst, .mem_req, .ack_cycle, .mem_addr, .slow,
        .casc_vec(8'h47), .mem_ready, .mem_rdata, .ack_vector);
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (mem_req && mem_write && mem_ready)
            wq.push_back(mem_wdata);
        if (ack_cycle && mem_ready)
            acks++;
    end
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    task automatic chk(string n, logic [19:0] e, logic [19:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one vectoring request; 8'hff means it must be refused
    task automatic vec(logic [15:0] c, logic [7:0] et);
        int n = 0;
        @(posedge clk);
        cz <= c;
        slow <= ~slow;
        wq.delete();
        acks = 0;
        // pin requests need four edges through the input filter
        repeat (4) @(posedge clk);
        instr_end <= 1'b1;
        @(posedge clk);
        instr_end <= 1'b0;
        while (vec_done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("done", et != 8'hff, n < 40);
        if (et != 8'hff) begin
            chk("type", et, vec_type);
            chk("ip", {et, 2'b00} ^ 16'ha5c3, new_ip);
            chk("cs", {et, 2'b10} ^ 16'ha5c3, new_cs);
            chk("flags", {6'h00, ie, c[7], 8'h5a}, wq[0]);
            chk("seg", cs, wq[1]);
            chk("ret", c[1] ? eip : nip, wq[2]);
            chk("status", 16'h005a, new_status);
            chk("ack", et == 8'h47, acks > 0);
        end
        @(posedge clk);
        cz <= 16'h0000;
    endtask
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        base_sel = CAV_BASE_NONE;
        idx_sel = CAV_IDX_NONE;
        disp_sel = CAV_DISP_NONE;
        seg_override_sel = CAV_SEG_ES;
        {string_op, seg_override, port_from_reg, instr_end} = 4'h0;
        {no_step_instr, slow, ie} = 3'h1;
        {disp, bx, bp, si, di, es, cs, ss, ds, dx, nip, eip, sp, cz} = '0;
        port_imm = 8'h00;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 300; k++) begin
            @(posedge clk);
            r = rnd();
            base_sel <= cav_base_e'(r[1:0] % 2'd3);
            idx_sel <= cav_idx_e'(r[3:2] % 2'd3);
            disp_sel <= cav_disp_e'(r[5:4] % 2'd3);
            seg_override_sel <= cav_seg_e'(r[7:6]);
            {seg_override, string_op, port_from_reg} <= r[10:8];
            port_imm <= r[15:8];
            {disp, bx, bp, si, di, dx} <= {rnd(), rnd(), rnd(), rnd(),
                rnd(), rnd()};
            {es, cs, ss, ds, nip, eip, sp} <= {rnd(), rnd(), rnd(), rnd(),
                rnd(), rnd(), rnd()};
            @(negedge clk);
            eo = (base_sel == CAV_BASE_GEN ? bx : base_sel == CAV_BASE_FRAME
                ? bp : 16'h0) + (idx_sel == CAV_IDX_SRC ? si : idx_sel ==
                CAV_IDX_DST ? di : 16'h0) + (disp_sel == CAV_DISP_8 ?
                {{8{disp[7]}}, disp[7:0]} : disp_sel == CAV_DISP_16 ? disp
                : 16'h0);
            s = seg_override ? seg_override_sel : base_sel == CAV_BASE_FRAME
                ? CAV_SEG_SS : string_op && idx_sel == CAV_IDX_DST ?
                CAV_SEG_ES : CAV_SEG_DS;
            r = s == CAV_SEG_ES ? es : s == CAV_SEG_CS ? cs : s == CAV_SEG_SS
                ? ss : ds;
            chk("offset", eo, eff_offset);
            chk("phys", {r, 4'h0} + eo, phys_addr);
            r = port_from_reg ? dx : {8'h00, port_imm};
            chk("port", r, io_port);
            eo = 16'(r >= PORT_RSV_LO && r <= PORT_RSV_HI);
            chk("rsvd", eo, io_reserved);
        end
        for (int i = 0; i < 16; i++)
            vec(16'h0001 << i, tbl[i]);
        vec(16'hfffe, VEC_ESC);
        vec(16'h8001, VEC_DIV);
        no_step_instr <= 1'b1;
        vec(16'h0080, 8'hff);
        no_step_instr <= 1'b0;
        ie <= 1'b0;
        vec(16'h0200, 8'hff);
        vec(16'h0100, VEC_NMI);
        report_and_stop();
    end
endmodule
bind cav_unit cav_properties chk (.clk, .rst, .port_from_reg, .port_imm,
    .port_address_reg, .io_port, .instr_end, .busy, .div_overflow,
    .status_word, .mem_req, .mem_write, .mem_addr, .mem_wdata, .vec_done,
    .vec_type, .new_status);
